// file: rtl/smsp_defs.vh
// Purpose: constants for the serial port master/slave block
// Assumes: byte-wide register port, offsets are byte indices
// Notes: every offset, the control and status field positions and the control reset values live here; baud fields are not
`ifndef SMSP_DEFS_VH
`define SMSP_DEFS_VH

// register offsets
`define SMSP_OFF_CTRL1 3'h0
`define SMSP_OFF_CTRL2 3'h1
`define SMSP_OFF_BAUD 3'h2
`define SMSP_OFF_STAT 3'h3
`define SMSP_OFF_DATH 3'h4
`define SMSP_OFF_DATL 3'h5
`define SMSP_OFF_RSV6 3'h6
`define SMSP_OFF_RSV7 3'h7

// control_one fields
`define SMSP_C1_IRQ_EN 7
`define SMSP_C1_PORT_EN 6
`define SMSP_C1_TXE_IE 5
`define SMSP_C1_MASTER 4
`define SMSP_C1_CLOCK_POLARITY 3
`define SMSP_C1_CLOCK_PHASE 2
`define SMSP_C1_SELECT_OUTPUT_ENABLE 1
`define SMSP_C1_LSBF 0

// control_two fields
`define SMSP_C2_WIDTH 6
`define SMSP_C2_FAULT_DETECT_ENABLE 4
`define SMSP_C2_SHARED_PIN_OUTPUT_ENABLE 3
`define SMSP_C2_HALTW 1
`define SMSP_C2_SWIRE 0

// status fields
`define SMSP_ST_DONE 7
`define SMSP_ST_TXE 5
`define SMSP_ST_MODE_FAULT_FLAG 4

// writable masks and reset values
`define SMSP_C2_MASK 8'h5b
`define SMSP_BR_MASK 8'h77
`define SMSP_C1_RESET 8'h04
`define SMSP_C2_RESET 8'h00
`define SMSP_BR_RESET 8'h00

`endif

// file: rtl/smsp_clkdiv.v
// Purpose: baud divider producing half-period ticks of the serial clock
// Assumes: divisor = (pre+1) * 2^(sel+1) bus clocks per serial clock period
// Notes: tick marks each serial clock edge; tick stays low and the count clears while run is low
`timescale 1ns/10ps

module smsp_clkdiv (
    input wire clk,
    input wire rst,
    input wire run,
    input wire [2:0] pre,
    input wire [2:0] sel,
    output reg tick
);
    reg [10:0] cnt_reg;
    wire [10:0] half;

    // half period in bus clocks, minus one
    assign half = ({8'h00, pre} + 11'h001) * (11'h001 << sel) - 11'h001;

    // ==========================================
    // counter
    always @(posedge clk) begin
        if (rst || !run) begin
            cnt_reg <= 11'h000;
            tick <= 1'b0;
        end else if (cnt_reg >= half) begin
            cnt_reg <= 11'h000;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 11'h001;
            tick <= 1'b0;
        end
    end
endmodule

// file: rtl/smsp_port.v
// Purpose: full-duplex synchronous serial port, master or slave, with register port
// Assumes: pins from outside pass two flip-flops; slave clock well below bus clock
// Notes: serial output enables are active low (low while driving)
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`include "smsp_defs.vh"

// Operation
// - wait mode with halt_in_wait clear behaves exactly like run mode.
// - wait with halt_in_wait set stops clock generation; master transfer pauses, resumes.
// - stop mode makes port inactive; master transfer halts and later continues.
// - slave keeps shifting in wait and stop to stay synchronised.
// - master drives MOSI; slave samples MOSI.
// - slave drives MISO; master samples MISO.
// - master may drive select output; slave takes select from external master.
// - master generates serial clock; slave uses external serial clock.
// - reserved bits read zero; writes to them have no effect.
// - control_one bit 7 gates interrupt on transfer done or mode fault.
// - control_one bit 6 enables port; clearing it idles and resets flags.
// - control_one bit 5 gates interrupt on transmit empty.
// - control_one bit 4 picks slave or master; any change forces idle.
// - control_one bit 3 sets clock idle level; both ends must match.
// - control_one bit 2 samples on odd edges when 0, even when 1.
// - master: changing polarity, phase, select output or bit order aborts transfer.
// - master select pin unused, fault input, or output per enables; slave input.
// - control_one bit 0 picks msb or lsb first; register bit positions unchanged.
// - control_two bit 6 picks 8-bit low byte or 16-bit word transfers.
// - control_two bit 4 enables mode fault detection; master change aborts.
// - control_two bit 0 enables single-wire pin use with separate output enable.
// - master clock rate is bus clock over divisor from baud fields.
module smsp_port (
    input wire clk,
    input wire rst,
    input wire wait_mode,
    input wire stop_mode,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    output reg irq,
    input wire mosi_in,
    output reg mosi_out,
    output reg mosi_oe_n,
    input wire miso_in,
    output reg miso_out,
    output reg miso_oe_n,
    input wire ss_in,
    output reg ss_out,
    output reg ss_oe_n,
    input wire sck_in,
    output reg sck_out,
    output reg sck_oe_n
);
    localparam ST_IDLE = 1'b0;
    localparam ST_SHIFT = 1'b1;

    reg [7:0] ctrl1_reg, ctrl2_reg, baud_reg;
    reg done_reg, txe_reg, mode_fault_flag_reg;
    reg stat_seen_reg;
    reg [15:0] txbuf_reg, rxbuf_reg, shift_reg;
    reg state_reg;
    reg [4:0] edge_reg;
    reg sck_int_reg;
    reg [1:0] mosi_s, miso_s, ss_s, sck_s;
    reg busy_q_reg, sck_q_reg;
    reg out_bit_reg;
    reg [7:0] rd_next;

    wire en = ctrl1_reg[`SMSP_C1_PORT_EN];
    wire mst = ctrl1_reg[`SMSP_C1_MASTER];
    wire clock_polarity = ctrl1_reg[`SMSP_C1_CLOCK_POLARITY];
    wire clock_phase = ctrl1_reg[`SMSP_C1_CLOCK_PHASE];
    wire lsbf = ctrl1_reg[`SMSP_C1_LSBF];
    wire wide = ctrl2_reg[`SMSP_C2_WIDTH];
    wire fault_detect_enable = ctrl2_reg[`SMSP_C2_FAULT_DETECT_ENABLE];
    wire swire = ctrl2_reg[`SMSP_C2_SWIRE];
    wire shared_pin_output_enable = ctrl2_reg[`SMSP_C2_SHARED_PIN_OUTPUT_ENABLE];
    wire [4:0] last_edge = wide ? 5'd31 : 5'd15;

    // master pause in stop, or wait with halt set; slave never pauses
    wire halted = stop_mode | (wait_mode & ctrl2_reg[`SMSP_C2_HALTW]);

    // ==========================================
    // pin synchronisers; only the second stage is read
    always @(posedge clk) begin
        mosi_s <= {mosi_s[0], mosi_in};
        miso_s <= {miso_s[0], miso_in};
        ss_s <= {ss_s[0], ss_in};
        sck_s <= {sck_s[0], sck_in};
    end
    wire mosi_sy = mosi_s[1];
    wire miso_sy = miso_s[1];
    wire ss_sy = ss_s[1];
    wire sck_sy = sck_s[1];

    // ==========================================
    // baud generator
    wire tick;
    smsp_clkdiv u_div (
        .clk(clk),
        .rst(rst),
        .run(en & mst & (state_reg == ST_SHIFT) & ~halted),
        .pre(baud_reg[6:4]),
        .sel(baud_reg[2:0]),
        .tick(tick)
    );

    // slave edges from the external clock, seen after sync
    wire sck_edge = (sck_sy ^ sck_q_reg);
    wire slave_sel = ~ss_sy;
    // input bit per mode
    wire din = mst ? (swire ? mosi_sy : miso_sy) : (swire ? miso_sy : mosi_sy);
    // mode fault: master with fault enable and select output enable clear, select input pulled low
    wire fault_in = en & mst & fault_detect_enable & ~ctrl1_reg[`SMSP_C1_SELECT_OUTPUT_ENABLE] & ~ss_sy;
    // outgoing bit position
    wire [3:0] top_bit = wide ? 4'd15 : 4'd7;
    wire dout = lsbf ? shift_reg[0] : shift_reg[top_bit];
    // shifter after taking in the incoming bit
    wire [15:0] shift_in = lsbf ? (wide ? {din, shift_reg[15:1]} : {8'h00, din, shift_reg[7:1]})
        : (wide ? {shift_reg[14:0], din} : {8'h00, shift_reg[6:0], din});

    // ==========================================
    // register writes and aborts
    wire wr_c1 = wr && addr == `SMSP_OFF_CTRL1;
    wire wr_c2 = wr && addr == `SMSP_OFF_CTRL2;
    wire wr_br = wr && addr == `SMSP_OFF_BAUD;
    wire wr_dl = wr && addr == `SMSP_OFF_DATL;
    wire wr_dh = wr && addr == `SMSP_OFF_DATH;
    wire [7:0] c2_new = wdata & `SMSP_C2_MASK;
    wire [7:0] br_new = wdata & `SMSP_BR_MASK;
    wire ab_c1 = wr_c1 && ((wdata[`SMSP_C1_MASTER] != mst) ||
        (mst && wdata[3:0] != ctrl1_reg[3:0]));
    wire ab_c2 = wr_c2 && mst && ((c2_new[`SMSP_C2_WIDTH] != wide) ||
        (c2_new[`SMSP_C2_FAULT_DETECT_ENABLE] != fault_detect_enable) || (c2_new[`SMSP_C2_SWIRE] != swire) ||
        (swire && c2_new[`SMSP_C2_SHARED_PIN_OUTPUT_ENABLE] != shared_pin_output_enable));
    wire ab_br = wr_br && mst && (br_new != baud_reg);
    wire abort = ab_c1 | ab_c2 | ab_br | ~en | fault_in;

    always @(posedge clk) begin
        if (rst) begin
            ctrl1_reg <= `SMSP_C1_RESET;
            ctrl2_reg <= `SMSP_C2_RESET;
            baud_reg <= `SMSP_BR_RESET;
        end else begin
            if (wr_c1)
                ctrl1_reg <= wdata;
            if (wr_c2)
                ctrl2_reg <= c2_new;
            if (wr_br)
                baud_reg <= br_new;
        end
    end

    // ==========================================
    // data buffers, flags and shifter
    wire start = en && txe_reg == 1'b0 && state_reg == ST_IDLE && !abort &&
        (mst ? ~halted : slave_sel);
    // a sampling edge is odd with phase 0, even with phase 1
    wire cur_edge = mst ? tick : (sck_edge & slave_sel);
    wire sample = ~(edge_reg[0] ^ clock_phase);
    wire last = (edge_reg == last_edge);
    wire [15:0] load_val = wide ? txbuf_reg : {8'h00, txbuf_reg[7:0]};
    // first bit on the line before any clock edge
    wire first_bit = lsbf ? load_val[0] : load_val[top_bit];
    wire [15:0] rx_done = wide ? shift_reg : {8'h00, shift_reg[7:0]};
    // clear of done: status read seen, then data low read
    wire clr_done = rd && addr == `SMSP_OFF_DATL && stat_seen_reg && done_reg;
    wire clr_txe = wr_dl && stat_seen_reg && txe_reg;

    always @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            edge_reg <= 5'd0;
            shift_reg <= 16'h0000;
            txbuf_reg <= 16'h0000;
            rxbuf_reg <= 16'h0000;
            done_reg <= 1'b0;
            txe_reg <= 1'b1;
            mode_fault_flag_reg <= 1'b0;
            stat_seen_reg <= 1'b0;
            sck_int_reg <= 1'b0;
            sck_q_reg <= 1'b0;
            busy_q_reg <= 1'b0;
            out_bit_reg <= 1'b0;
        end else begin
            sck_q_reg <= sck_sy;
            busy_q_reg <= (state_reg == ST_SHIFT); // keeps select low past the last edge
            if (rd && addr == `SMSP_OFF_STAT)
                stat_seen_reg <= 1'b1;
            else if (clr_done || clr_txe)
                stat_seen_reg <= 1'b0;
            if (wr_dh)
                txbuf_reg[15:8] <= wdata;
            if (wr_dl)
                txbuf_reg[7:0] <= wdata;
            // flags: hardware set beats software clear
            if (clr_txe)
                txe_reg <= 1'b0;
            if (clr_done)
                done_reg <= 1'b0;
            if (fault_in)
                mode_fault_flag_reg <= 1'b1;
            else if (rd && addr == `SMSP_OFF_CTRL1 && stat_seen_reg)
                mode_fault_flag_reg <= 1'b0;
            if (abort) begin
                state_reg <= ST_IDLE;
                edge_reg <= 5'd0;
                sck_int_reg <= 1'b0;
                if (!en) begin
                    done_reg <= 1'b0;
                    txe_reg <= 1'b1;
                    mode_fault_flag_reg <= 1'b0;
                end
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        edge_reg <= 5'd0;
                        sck_int_reg <= 1'b0;
                        if (start) begin
                            shift_reg <= load_val;
                            out_bit_reg <= first_bit;
                            txe_reg <= 1'b1;
                            state_reg <= ST_SHIFT;
                        end
                    end
                    ST_SHIFT: begin
                        if (!mst && !slave_sel) begin
                            state_reg <= ST_IDLE;
                        end else if (cur_edge) begin
                            if (mst)
                                sck_int_reg <= ~sck_int_reg;
                            edge_reg <= edge_reg + 5'd1;
                            // take in on sampling edges, move the line on the others
                            if (sample)
                                shift_reg <= shift_in;
                            else
                                out_bit_reg <= dout;
                            if (last) begin
                                rxbuf_reg <= sample ? shift_in : rx_done;
                                done_reg <= 1'b1;
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // ==========================================
    // read mux; reserved bits and offsets read zero
    always @* begin
        case (addr)
            `SMSP_OFF_CTRL1: rd_next = ctrl1_reg;
            `SMSP_OFF_CTRL2: rd_next = ctrl2_reg;
            `SMSP_OFF_BAUD: rd_next = baud_reg;
            `SMSP_OFF_STAT: rd_next = {done_reg, 1'b0, txe_reg, mode_fault_flag_reg, 4'h0};
            `SMSP_OFF_DATH: rd_next = wide ? rxbuf_reg[15:8] : 8'h00;
            `SMSP_OFF_DATL: rd_next = rxbuf_reg[7:0];
            default: rd_next = 8'h00;
        endcase
    end

    // ==========================================
    // registered outputs: read data, interrupt, pins
    always @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
            irq <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe_n <= 1'b1;
            miso_out <= 1'b0;
            miso_oe_n <= 1'b1;
            ss_out <= 1'b1;
            ss_oe_n <= 1'b1;
            sck_out <= 1'b0;
            sck_oe_n <= 1'b1;
        end else begin
            rdata <= rd ? rd_next : 8'h00;
            irq <= (ctrl1_reg[`SMSP_C1_IRQ_EN] & (done_reg | mode_fault_flag_reg)) |
                (ctrl1_reg[`SMSP_C1_TXE_IE] & txe_reg);
            mosi_out <= out_bit_reg;
            miso_out <= out_bit_reg;
            // master drives clock, idle level from polarity
            sck_out <= clock_polarity ^ sck_int_reg;
            sck_oe_n <= ~(en & mst);
            mosi_oe_n <= ~(en & mst & (~swire | shared_pin_output_enable));
            miso_oe_n <= ~(en & ~mst & slave_sel & (~swire | shared_pin_output_enable));
            ss_oe_n <= ~(en & mst & fault_detect_enable & ctrl1_reg[`SMSP_C1_SELECT_OUTPUT_ENABLE]);
            ss_out <= ~((state_reg == ST_SHIFT) | busy_q_reg);
        end
    end
endmodule

// file: test/smsp_port_properties.sv
// Purpose: timing relations at the ports of the serial port block
// Assumes: control_one shadowed from bus writes; pins registered
// Notes: one clock domain, synchronous reset
`timescale 1ns/10ps
`include "smsp_defs.vh"
module smsp_port_properties (
    input wire clk,
    input wire rst,
    input wire wait_mode,
    input wire stop_mode,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire irq,
    input wire mosi_in,
    input wire mosi_out,
    input wire mosi_oe_n,
    input wire miso_in,
    input wire miso_out,
    input wire miso_oe_n,
    input wire ss_in,
    input wire ss_out,
    input wire ss_oe_n,
    input wire sck_in,
    input wire sck_out,
    input wire sck_oe_n
);
    reg [7:0] c1_reg;
    wire m_en = c1_reg[6] & c1_reg[4];
    // shadow of control_one as written over the bus
    always @(posedge clk) begin
        if (rst)
            c1_reg <= `SMSP_C1_RESET;
        else if (wr && addr == `SMSP_OFF_CTRL1)
            c1_reg <= wdata;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ====================================
    // register port and pin checks
    a_reserved_zero: assert property (rd && addr[2:1] == 2'b11 |=> rdata == 8'h00)
        else $error("reserved offset read not zero");
    a_ctrl2_mask: assert property (rd && addr == `SMSP_OFF_CTRL2 |=> (rdata & ~`SMSP_C2_MASK) == 8'h00)
        else $error("control_two reserved bits set");
    a_baud_mask: assert property (rd && addr == `SMSP_OFF_BAUD |=> (rdata & ~`SMSP_BR_MASK) == 8'h00)
        else $error("baud_select reserved bits set");
    a_ctrl1_read: assert property (rd && addr == `SMSP_OFF_CTRL1 |=> rdata == $past(c1_reg))
        else $error("control_one read differs from written value");
    a_slave_pins: assert property (!c1_reg[4] && !$past(c1_reg[4]) |-> mosi_oe_n && sck_oe_n && ss_oe_n)
        else $error("slave drives a master pin");
    a_master_miso: assert property (m_en && $past(m_en) |-> miso_oe_n)
        else $error("master drives miso");
    a_disabled_idle: assert property (!c1_reg[6] && !$past(c1_reg[6])
        |-> mosi_oe_n && miso_oe_n && sck_oe_n && ss_oe_n)
        else $error("disabled port drives a pin");
    a_irq_gate: assert property (!(c1_reg[7] | c1_reg[5]) && !($past(c1_reg[7]) | $past(c1_reg[5])) |-> !irq)
        else $error("interrupt raised while gated off");
    a_sck_idle: assert property (m_en && $past(m_en) && c1_reg == $past(c1_reg) && !ss_oe_n && ss_out
        && $past(ss_out) |-> sck_out == c1_reg[3])
        else $error("serial clock not at idle level");
    a_stop_hold: assert property (m_en && stop_mode && $past(stop_mode) && $past(stop_mode, 2)
        && $past(stop_mode, 3) |-> $stable(sck_out))
        else $error("serial clock moved in stop");
    a_abort_idle: assert property (m_en && !ss_oe_n && !ss_out && wr && addr == `SMSP_OFF_CTRL1 && wdata[6]
        && wdata[4] && wdata[1] && wdata[3:0] != c1_reg[3:0] |-> ##[1:4] ss_out)
        else $error("transfer not aborted on config change");
endmodule

// file: test/smsp_slave_model.sv
// Purpose: behavioural serial peer acting as slave to the port
// Assumes: mode bits handed in by the bench, 8-bit words
// Notes: miso shows the inverse of its last bit when deselected
`timescale 1ns/10ps
module smsp_slave_model (
    input wire sck,
    input wire mosi,
    input wire ss_n,
    input wire clock_polarity,
    input wire clock_phase,
    input wire lsbf,
    input wire [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic [3:0] k = 4'h0;
    logic [3:0] o = 4'h0;
    initial miso = 1'b0;
    initial rx_byte = 8'h00;
    function automatic int ix(input logic [3:0] n);
        return lsbf ? n : 7 - n;
    endfunction
    // ====================================
    // framing and shifting
    // select start, phase 0 shows first bit at once
    always @(negedge ss_n) begin
        k = 4'h0;
        o = 4'h0;
        if (!clock_phase) begin
            miso = tx_byte[ix(0)];
            o = 4'h1;
        end
    end
    // released line no longer shows the last bit
    always @(posedge ss_n) miso = ~miso;
    // sample or shift on each edge of the master clock
    always @(sck) begin
        if (!ss_n) begin
            if (sck == !(clock_polarity ^ clock_phase)) begin
                rx_byte[ix(k)] = mosi;
                k = k + 4'h1;
            end else if (o < 4'h8) begin
                miso = tx_byte[ix(o)];
                o = o + 4'h1;
            end
        end
    end
endmodule

// file: test/test_spi_master_slave_port.sv
// Purpose: self-checking bench for the serial port in master mode
// Assumes: pull-down on sck and mosi, pull-up on select
// Notes: random words from an xorshift seeded with 56
`timescale 1ns/10ps
`include "smsp_defs.vh"
module test_spi_master_slave_port;
    logic clk = 1'b0, rst = 1'b1, wait_mode = 1'b0, stop_mode = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [2:0] addr = 3'h0, cfg = 3'h0;
    logic [7:0] wdata = 8'h00, p_tx = 8'h00, d, s, b, p;
    logic [31:0] seed = 32'h0000_0038;
    logic k;
    int num_errors = 0, n_checks = 0, cyc = 0, m, j;
    wire [7:0] rdata, p_rx;
    wire irq, mosi_out, mosi_oe_n, miso_out, miso_oe_n, ss_out, ss_oe_n, sck_out, sck_oe_n, m_miso;
    wire sck_w = sck_oe_n ? 1'b0 : sck_out;
    wire ss_w = ss_oe_n ? 1'b1 : ss_out;
    wire mosi_w = mosi_oe_n ? 1'b0 : mosi_out;
    wire miso_w = miso_oe_n ? m_miso : miso_out;
    always #2.5 clk = ~clk;
    smsp_port u_dut (.clk(clk), .rst(rst), .wait_mode(wait_mode), .stop_mode(stop_mode), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .mosi_in(mosi_w), .mosi_out(mosi_out),
        .mosi_oe_n(mosi_oe_n), .miso_in(miso_w), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .ss_in(ss_w),
        .ss_out(ss_out), .ss_oe_n(ss_oe_n), .sck_in(sck_w), .sck_out(sck_out), .sck_oe_n(sck_oe_n));
    smsp_slave_model u_peer (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w), .clock_polarity(cfg[2]), .clock_phase(cfg[1]),
        .lsbf(cfg[0]), .tx_byte(p_tx), .miso(m_miso), .rx_byte(p_rx));
    // ====================================
    // helpers
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic logic [7:0] c1_of(input logic [2:0] md);
        return {4'h5, md[2], md[1], 1'b1, md[0]};
    endfunction
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic start_x(input logic [7:0] bv, input logic [7:0] pv);
        p_tx = pv;
        rd_reg(`SMSP_OFF_STAT, s);
        wr_reg(`SMSP_OFF_DATL, bv);
    endtask
    task automatic end_x(input logic [7:0] bv, input logic [7:0] pv);
        int i;
        s = 8'h00;
        for (i = 0; i < 600 && s[7] !== 1'b1; i++) rd_reg(`SMSP_OFF_STAT, s);
        chk("status", 8'ha0, s);
        rd_reg(`SMSP_OFF_DATL, d);
        chk("rx data", pv, d);
        chk("peer rx", bv, p_rx);
    endtask
    task stop_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // cycle ceiling
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            $display("ERROR timeout expected done seen hang");
            stop_test;
        end
    end
    // ====================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`SMSP_OFF_CTRL1, d);
        chk("control_one", `SMSP_C1_RESET, d);
        wr_reg(`SMSP_OFF_RSV6, 8'hff);
        rd_reg(`SMSP_OFF_RSV6, d);
        chk("reserved_six", 8'h00, d);
        rd_reg(`SMSP_OFF_RSV7, d);
        chk("reserved_seven", 8'h00, d);
        wr_reg(`SMSP_OFF_CTRL2, 8'hff);
        rd_reg(`SMSP_OFF_CTRL2, d);
        chk("control_two", `SMSP_C2_MASK, d);
        wr_reg(`SMSP_OFF_BAUD, 8'hff);
        rd_reg(`SMSP_OFF_BAUD, d);
        chk("baud_select", `SMSP_BR_MASK, d);
        wr_reg(`SMSP_OFF_CTRL2, 8'h10);
        $display("test registers done");
        for (m = 0; m < 8; m++) begin
            b = rnd();
            cfg = m[2:0];
            wait_mode <= m[0];
            wr_reg(`SMSP_OFF_BAUD, {2'b00, b[0], 1'b1, 2'b00, b[1], ~b[1]});
            wr_reg(`SMSP_OFF_CTRL1, c1_of(cfg));
            b = rnd();
            p = rnd();
            start_x(b, p);
            end_x(b, p);
        end
        wait_mode <= 1'b0;
        $display("test modes done");
        for (j = 0; j < 2; j++) begin
            wr_reg(`SMSP_OFF_CTRL2, {6'h04, j[0], 1'b0});
            b = rnd();
            p = rnd();
            start_x(b, p);
            repeat (12) @(posedge clk);
            if (j == 0) stop_mode <= 1'b1;
            else wait_mode <= 1'b1;
            repeat (4) @(posedge clk);
            k = sck_w;
            repeat (40) @(posedge clk);
            chk("sck held", {7'h00, k}, {7'h00, sck_w});
            chk("select held", 8'h00, {7'h00, ss_w});
            stop_mode <= 1'b0;
            wait_mode <= 1'b0;
            end_x(b, p);
        end
        $display("test pause done");
        start_x(rnd(), rnd());
        repeat (20) @(posedge clk);
        cfg = cfg ^ 3'b100;
        wr_reg(`SMSP_OFF_CTRL1, c1_of(cfg));
        repeat (6) @(posedge clk);
        chk("select after abort", 8'h01, {7'h00, ss_w});
        rd_reg(`SMSP_OFF_STAT, s);
        chk("done after abort", 8'h00, s & 8'h80);
        cfg = 3'h0;
        wr_reg(`SMSP_OFF_CTRL1, c1_of(cfg) | 8'h20);
        repeat (3) @(posedge clk);
        chk("irq tx empty", 8'h01, {7'h00, irq});
        wr_reg(`SMSP_OFF_CTRL1, c1_of(cfg));
        repeat (3) @(posedge clk);
        chk("irq masked", 8'h00, {7'h00, irq});
        wr_reg(`SMSP_OFF_CTRL1, 8'h00);
        repeat (3) @(posedge clk);
        chk("pin enables", 8'h0f, {4'h0, sck_oe_n, mosi_oe_n, miso_oe_n, ss_oe_n});
        rd_reg(`SMSP_OFF_STAT, s);
        chk("flags disabled", 8'h00, s & 8'h90);
        $display("test abort irq disable done");
        stop_test;
    end
endmodule
bind smsp_port smsp_port_properties u_props (.clk(clk), .rst(rst), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .mosi_in(mosi_in),
    .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_in), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .ss_in(ss_in), .ss_out(ss_out), .ss_oe_n(ss_oe_n), .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n));
